// ==== hdl/cna_pkg.sv ====
// constants and carrier types for the node configuration and bus access
// assumes a single 20 MHz clock and a synchronous active-high reset
// Function
// - node address limited to 1 through 127
// - no bus path changes node address
// - only seven listed bit rates supported
// - factory default bit rate 125 kbit/s
// - bit rate changed only locally
// - edits refused outside local edit mode
// - new address applies only after save
// - edit mode silences all bus activity
// - leaving edit mode resumes bus activity
// - transmit only after bus seen idle
// - compare each driven bit with bus
// - stop at once on lost arbitration
// - process data outranks service data
// - smaller address gives higher priority
// - standard 11-bit identifiers only
// - identifier is function code plus address
// - lower identifier wins arbitration
package cna_pkg;
    localparam int CLK_KHZ = 20000;
    // bit rate selector codes
    localparam logic [2:0] RATE_1000K = 3'h0;
    localparam logic [2:0] RATE_800K = 3'h1;
    localparam logic [2:0] RATE_500K = 3'h2;
    localparam logic [2:0] RATE_250K = 3'h3;
    localparam logic [2:0] RATE_125K = 3'h4;
    localparam logic [2:0] RATE_50K = 3'h5;
    localparam logic [2:0] RATE_20K = 3'h6;
    localparam logic [2:0] RATE_COUNT = 3'h7;
    localparam int RATE_KBPS [7] = '{1000, 800, 500, 250, 125, 50, 20};
    localparam int DIV_MAX = CLK_KHZ / 20;
    localparam int DIV_W = $clog2(DIV_MAX + 1);
    // reset values
    localparam logic [6:0] NODE_DEFAULT = 7'h01;
    localparam logic [2:0] RATE_DEFAULT = RATE_125K;
    localparam logic [6:0] NODE_MIN = 7'h01;
    // function codes, upper four identifier bits
    localparam logic [3:0] FUNC_TX_PDO1 = 4'h3;
    localparam logic [3:0] FUNC_TX_SDO = 4'hb;
    localparam logic [3:0] FUNC_RX_SDO = 4'hc;
    localparam logic [3:0] FUNC_NMT = 4'h0;
    // frame layout: start bit, 11 identifier bits, remote bit
    localparam int ID_W = 11;
    localparam logic [3:0] ARB_BITS = 4'hd;
    localparam logic [3:0] IDLE_BITS = 4'hb;
    localparam logic BIT_DOMINANT = 1'b0;
    localparam logic BIT_RECESSIVE = 1'b1;

    typedef enum logic {KIND_PDO, KIND_SDO} cna_kind_type;

    typedef struct packed {
        logic [6:0] nodeId;
        logic [2:0] rate;
    } cna_cfg_type;

    typedef struct packed {
        logic valid;
        logic ide;
        logic [ID_W-1:0] id;
    } cna_rx_type;
endpackage

// ==== hdl/cna_bit_div.sv ====
// bit-time enable divider for the selected bus bit rate
// assumes the rate code was range-checked before it reaches this module
`timescale 1ns/1ps
module cna_bit_div #(
    parameter int CLK_KHZ = cna_pkg::CLK_KHZ
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [2:0] rate,
    output logic bitTick
);
    typedef struct packed {
        logic [cna_pkg::DIV_W-1:0] cnt;
        logic [2:0] rate;
        logic tick;
    } cna_div_state_type;

    cna_div_state_type st_r;
    cna_div_state_type st_nxt;
    logic [cna_pkg::DIV_W-1:0] divLast;

    // refuse clocks that are not whole megahertz or that leave an oversized divisor
    if (CLK_KHZ % 1000 != 0
            || CLK_KHZ / 20 > cna_pkg::DIV_MAX) begin : g_bad_clk
        $error("clock rate cannot serve the listed bit rates");
    end

    // divisor minus one; each divisor comes out whole at 20 MHz
    always_comb begin
        divLast = cna_pkg::DIV_W'(CLK_KHZ / cna_pkg::RATE_KBPS[st_r.rate] - 1);
    end

    // a rate change restarts the count so no stretched bit leaks out
    always_comb begin
        st_nxt = st_r;
        st_nxt.tick = 1'b0;
        st_nxt.rate = rate;
        if (rate != st_r.rate) begin
            st_nxt.cnt = '0;
        end else if (st_r.cnt == divLast) begin
            st_nxt.cnt = '0;
            st_nxt.tick = 1'b1;
        end else begin
            st_nxt.cnt = st_r.cnt + 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            st_r <= '{cnt: '0, rate: cna_pkg::RATE_DEFAULT, tick: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign bitTick = st_r.tick;

    property p_tick_spacing;
        @(posedge sys_clk) disable iff (sys_rst)
        $rose(bitTick) && st_r.rate == cna_pkg::RATE_1000K
            && rate == cna_pkg::RATE_1000K |=> !bitTick [*8];
    endproperty
    a_tick_spacing: assert property (p_tick_spacing)
        else $error("bit enable repeated too early at 1 Mbit/s");
endmodule

// ==== hdl/cna_node_access.sv ====
// node configuration and bus arbitration front end
// assumes an outside controller sends the frame body once arbitration is won
`timescale 1ns/1ps
module cna_node_access (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic editMode,
    input wire logic [6:0] editNodeId,
    input wire logic editNodeWr,
    input wire logic [2:0] editRate,
    input wire logic editRateWr,
    input wire logic editSave,
    output logic editRefused,
    output cna_pkg::cna_cfg_type activeCfg,
    output logic busOnline,
    input wire logic txReq,
    input wire cna_pkg::cna_kind_type txKind,
    output logic txBusy,
    output logic txWon,
    output logic txLost,
    output logic [10:0] txId,
    input wire cna_pkg::cna_rx_type rxFrame,
    output logic rxAccept,
    input wire logic canRx,
    output logic canTx,
    output logic bitTick
);
    typedef enum logic [1:0] {ST_OFFLINE, ST_LISTEN, ST_IDLE, ST_ARB}
        cna_arb_type;

    typedef struct packed {
        cna_arb_type arb;
        cna_pkg::cna_cfg_type saved;
        cna_pkg::cna_cfg_type active;
        logic [6:0] pendNode;
        logic [3:0] bitCnt;
        logic [10:0] id;
        logic txBit;
        logic busy;
        logic won;
        logic lost;
        logic refused;
        logic accept;
    } cna_state_type;

    cna_state_type st_r;
    cna_state_type st_nxt;
    logic [12:0] frameBits;
    logic [3:0] func;

    cna_bit_div #(.CLK_KHZ(cna_pkg::CLK_KHZ)) u_div (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .rate(st_r.active.rate),
        .bitTick(bitTick)
    );

    // process data code is lower than service reply code
    always_comb begin
        func = (txKind == cna_pkg::KIND_PDO) ? cna_pkg::FUNC_TX_PDO1
                                             : cna_pkg::FUNC_TX_SDO;
    end

    // start bit, identifier msb first, remote bit dominant for data frame
    always_comb begin
        frameBits = {cna_pkg::BIT_DOMINANT, st_r.id, cna_pkg::BIT_DOMINANT};
    end

    always_comb begin
        st_nxt = st_r;
        st_nxt.won = 1'b0;
        st_nxt.lost = 1'b0;
        st_nxt.refused = 1'b0;
        st_nxt.accept = 1'b0;

        // local edits, only path to address and rate
        if ((editNodeWr || editRateWr || editSave) && !editMode) begin
            st_nxt.refused = 1'b1;
        end
        if (editMode && editNodeWr) begin
            if (editNodeId >= cna_pkg::NODE_MIN) begin
                st_nxt.pendNode = editNodeId;
            end else begin
                st_nxt.refused = 1'b1;
            end
        end
        if (editMode && editRateWr) begin
            if (editRate < cna_pkg::RATE_COUNT) begin
                st_nxt.saved.rate = editRate;
            end else begin
                st_nxt.refused = 1'b1;
            end
        end
        if (editMode && editSave) begin
            st_nxt.saved.nodeId = st_r.pendNode;
        end

        // arbitration and presence on the bus
        unique case (st_r.arb)
            ST_OFFLINE: begin
                st_nxt.txBit = cna_pkg::BIT_RECESSIVE;
                if (!editMode) begin
                    st_nxt.active = st_r.saved;
                    st_nxt.arb = ST_LISTEN;
                    st_nxt.bitCnt = '0;
                end
            end
            ST_LISTEN: begin
                // a dominant bit restarts the idle count
                if (bitTick) begin
                    if (canRx == cna_pkg::BIT_DOMINANT) begin
                        st_nxt.bitCnt = '0;
                    end else if (st_r.bitCnt == cna_pkg::IDLE_BITS - 1'b1) begin
                        st_nxt.arb = ST_IDLE;
                    end else begin
                        st_nxt.bitCnt = st_r.bitCnt + 1'b1;
                    end
                end
            end
            ST_IDLE: begin
                if (bitTick && canRx == cna_pkg::BIT_DOMINANT) begin
                    st_nxt.arb = ST_LISTEN;
                    st_nxt.bitCnt = '0;
                end else if (txReq && !st_r.busy) begin
                    st_nxt.id = {func, st_r.active.nodeId};
                    st_nxt.busy = 1'b1;
                    st_nxt.arb = ST_ARB;
                    st_nxt.bitCnt = '0;
                    st_nxt.txBit = cna_pkg::BIT_DOMINANT;
                end
            end
            ST_ARB: begin
                // sample at bit end, then drive the next bit
                if (bitTick) begin
                    if (canRx != st_r.txBit) begin
                        st_nxt.txBit = cna_pkg::BIT_RECESSIVE;
                        st_nxt.lost = 1'b1;
                        st_nxt.busy = 1'b0;
                        st_nxt.arb = ST_LISTEN;
                        st_nxt.bitCnt = '0;
                    end else if (st_r.bitCnt == cna_pkg::ARB_BITS - 1'b1) begin
                        st_nxt.txBit = cna_pkg::BIT_RECESSIVE;
                        st_nxt.won = 1'b1;
                        st_nxt.busy = 1'b0;
                        st_nxt.arb = ST_LISTEN;
                        st_nxt.bitCnt = '0;
                    end else begin
                        st_nxt.bitCnt = st_r.bitCnt + 1'b1;
                        st_nxt.txBit = frameBits[4'd11 - st_r.bitCnt];
                    end
                end
            end
        endcase

        // edit mode overrides everything and leaves the bus at once
        if (editMode) begin
            st_nxt.arb = ST_OFFLINE;
            st_nxt.txBit = cna_pkg::BIT_RECESSIVE;
            st_nxt.busy = 1'b0;
            // a win on the same edge is dropped, the attempt counts as lost
            st_nxt.won = 1'b0;
            st_nxt.lost = st_r.busy;
        end

        // receive filter: standard ids, service requests to this node or any NMT function code
        st_nxt.accept = rxFrame.valid && !rxFrame.ide
            && !editMode && st_r.arb != ST_OFFLINE
            && (rxFrame.id == {cna_pkg::FUNC_RX_SDO, st_r.active.nodeId}
                || rxFrame.id[10:7] == cna_pkg::FUNC_NMT);
    end

    // settings sit in registers that only reset and local edits touch
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            st_r <= '{arb: ST_OFFLINE,
                saved: '{nodeId: cna_pkg::NODE_DEFAULT,
                         rate: cna_pkg::RATE_DEFAULT},
                active: '{nodeId: cna_pkg::NODE_DEFAULT,
                          rate: cna_pkg::RATE_DEFAULT},
                pendNode: cna_pkg::NODE_DEFAULT,
                bitCnt: '0, id: '0, txBit: cna_pkg::BIT_RECESSIVE,
                busy: 1'b0, won: 1'b0, lost: 1'b0,
                refused: 1'b0, accept: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign canTx = st_r.txBit;
    assign activeCfg = st_r.active;
    assign busOnline = st_r.arb != ST_OFFLINE;
    assign txBusy = st_r.busy;
    assign txWon = st_r.won;
    assign txLost = st_r.lost;
    assign txId = st_r.id;
    assign editRefused = st_r.refused;
    assign rxAccept = st_r.accept;

    property p_silent_in_edit;
        @(posedge sys_clk) disable iff (sys_rst)
        editMode |=> canTx == cna_pkg::BIT_RECESSIVE && !txWon;
    endproperty
    a_silent_in_edit: assert property (p_silent_in_edit)
        else $error("bus driven while in edit mode");

    property p_rejoin;
        @(posedge sys_clk) disable iff (sys_rst)
        $fell(editMode) |=> busOnline && activeCfg == $past(st_r.saved);
    endproperty
    a_rejoin: assert property (p_rejoin)
        else $error("saved settings not applied on rejoining");

    property p_refuse;
        @(posedge sys_clk) disable iff (sys_rst)
        !editMode && (editNodeWr || editRateWr) |=> editRefused;
    endproperty
    a_refuse: assert property (p_refuse)
        else $error("edit outside edit mode not refused");

    property p_node_range;
        @(posedge sys_clk) disable iff (sys_rst)
        activeCfg.nodeId != 7'h00 && activeCfg.rate < cna_pkg::RATE_COUNT;
    endproperty
    a_node_range: assert property (p_node_range)
        else $error("active address or rate out of range");

    property p_save_needed;
        @(posedge sys_clk) disable iff (sys_rst)
        !editSave |=> st_r.saved.nodeId == $past(st_r.saved.nodeId);
    endproperty
    a_save_needed: assert property (p_save_needed)
        else $error("address changed without save");

    property p_start_idle;
        @(posedge sys_clk) disable iff (sys_rst)
        $rose(txBusy) |-> $past(st_r.arb) == ST_IDLE;
    endproperty
    a_start_idle: assert property (p_start_idle)
        else $error("transmission started on a busy bus");

    property p_backoff;
        @(posedge sys_clk) disable iff (sys_rst)
        st_r.arb == ST_ARB && bitTick && canRx != canTx
            |=> txLost && canTx == cna_pkg::BIT_RECESSIVE;
    endproperty
    a_backoff: assert property (p_backoff)
        else $error("no back-off after a bit mismatch");

    property p_id_form;
        @(posedge sys_clk) disable iff (sys_rst)
        $rose(txBusy) |-> txId[6:0] == activeCfg.nodeId
            && (txId[10:7] == cna_pkg::FUNC_TX_PDO1
                || txId[10:7] == cna_pkg::FUNC_TX_SDO);
    endproperty
    a_id_form: assert property (p_id_form)
        else $error("identifier not function code plus address");
endmodule

// ==== bench/cna_bus_peer.sv ====
// far-side node model that contends for the bus with the block
// assumes bitTick comes from the block and the bus is wired-and
`timescale 1ns/1ps
module cna_bus_peer (
    input wire logic sys_clk,
    input wire logic bitTick,
    input wire logic dutTx,
    input wire logic contend,
    input wire logic hold,
    input wire logic [10:0] peerId,
    output logic canBus
);
    logic on = 1'b0;
    logic [3:0] idx = 4'h0;
    logic [3:0] quiet = 4'h0;
    logic [12:0] bits;
    logic myBit;
    // start bit, identifier msb first, dominant remote bit
    assign bits = {1'b0, peerId, 1'b0};
    assign myBit = on ? bits[4'd12 - idx] : 1'b1;
    // released lines float recessive; any dominant driver wins
    assign canBus = dutTx & myBit & ~hold;
    // joins only on a frame start after an idle bus, never mid-frame
    always @(posedge sys_clk) begin
        if (bitTick) begin
            if (!canBus) quiet <= 4'h0;
            else if (quiet != 4'hb) quiet <= quiet + 4'h1;
        end
        if (!on && contend && !dutTx && quiet == 4'hb) begin
            on <= 1'b1;
            idx <= 4'h0;
        end else if (on && bitTick) begin
            if ((myBit && !canBus) || idx == 4'hc) on <= 1'b0;
            else idx <= idx + 4'h1;
        end
    end
endmodule

// ==== bench/tb_top.sv ====
// random and corner-case bench for the node access block
// assumes the peer model stands on the bus beside the block
`timescale 1ns/1ps
module tb_top;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic editMode = 1'b0;
    logic [6:0] editNodeId = 7'h00;
    logic editNodeWr = 1'b0;
    logic [2:0] editRate = 3'h0;
    logic editRateWr = 1'b0;
    logic editSave = 1'b0;
    logic txReq = 1'b0;
    cna_pkg::cna_kind_type txKind = cna_pkg::KIND_PDO;
    cna_pkg::cna_rx_type rxFrame = '0;
    logic contend = 1'b0;
    logic hold = 1'b0;
    logic [10:0] peerId = 11'h000;
    logic editRefused, busOnline, txBusy, txWon, txLost, rxAccept;
    logic canRx, canTx, bitTick, w;
    logic [10:0] txId, rid;
    cna_pkg::cna_cfg_type activeCfg;
    int errors = 0;
    int checks_done = 0;
    int cyc = 0;
    int seed = 19;
    logic [6:0] nd;

    always #25 sys_clk = ~sys_clk;

    cna_node_access cna_node_access_i (.sys_clk(sys_clk),
        .sys_rst(sys_rst), .editMode(editMode), .editNodeId(editNodeId),
        .editNodeWr(editNodeWr), .editRate(editRate),
        .editRateWr(editRateWr), .editSave(editSave),
        .editRefused(editRefused), .activeCfg(activeCfg),
        .busOnline(busOnline), .txReq(txReq), .txKind(txKind),
        .txBusy(txBusy), .txWon(txWon), .txLost(txLost), .txId(txId),
        .rxFrame(rxFrame), .rxAccept(rxAccept), .canRx(canRx),
        .canTx(canTx), .bitTick(bitTick));
    cna_bus_peer cna_bus_peer_i (.sys_clk(sys_clk), .bitTick(bitTick),
        .dutTx(canTx), .contend(contend), .hold(hold), .peerId(peerId),
        .canBus(canRx));

    task automatic chk(input string nm, input logic [15:0] ex,
        input logic [15:0] got);
        checks_done++;
        if (got !== ex) begin
            errors++;
            $display("MISMATCH %s exp %h got %h", nm, ex, got);
        end
    endtask

    task automatic report_and_stop;
        $display("errors %0d checks %0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // ceiling far above the few frames this run sends
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            errors++;
            report_and_stop();
        end
    end

    // one-cycle edit strobe, then look at the refusal pulse
    task automatic ed(input int k, input logic [6:0] v, input logic ex);
        @(posedge sys_clk);
        editNodeId <= v;
        editRate <= v[2:0];
        editNodeWr <= (k == 0);
        editRateWr <= (k == 1);
        editSave <= (k == 2);
        @(posedge sys_clk);
        editNodeWr <= 1'b0;
        editRateWr <= 1'b0;
        editSave <= 1'b0;
        @(negedge sys_clk);
        chk("editRefused", 16'(ex), 16'(editRefused));
    endtask

    // cycles from one bit enable to the next
    task automatic tick_gap(input int kbps);
        int gap;
        gap = 0;
        @(negedge sys_clk iff bitTick === 1'b1);
        do begin
            @(negedge sys_clk);
            gap++;
        end while (bitTick !== 1'b1 && gap < 2000);
        chk("tickGap", 16'(cna_pkg::CLK_KHZ / kbps), 16'(gap));
    endtask

    task automatic mode(input logic m);
        @(posedge sys_clk);
        editMode <= m;
        repeat (3) @(negedge sys_clk);
    endtask

    task automatic rx(input logic ide, input logic [10:0] id,
        input logic ex);
        @(posedge sys_clk);
        rxFrame <= {1'b1, ide, id};
        @(posedge sys_clk);
        rxFrame <= '0;
        @(negedge sys_clk);
        chk("rxAccept", 16'(ex), 16'(rxAccept));
    endtask

    // request held until taken; ab enters edit mode once busy
    task automatic send(input cna_pkg::cna_kind_type k, input logic ab);
        logic seen;
        seen = 1'b0;
        w = 1'bx;
        @(posedge sys_clk);
        txKind <= k;
        txReq <= 1'b1;
        for (int n = 0; n < 4000; n++) begin
            @(negedge sys_clk);
            if (txWon === 1'b1 || txLost === 1'b1) begin
                w = txWon;
                chk("txBusy", 16'h0, 16'(txBusy));
                chk("canTx", 16'h1, 16'(canTx));
                break;
            end
            if (txBusy === 1'b1) begin
                if (!seen) chk("canTx", 16'h0, 16'(canTx));
                seen = 1'b1;
                @(posedge sys_clk);
                txReq <= 1'b0;
                if (ab) editMode <= 1'b1;
            end
        end
    endtask

    initial begin
        repeat (12) @(posedge sys_clk);
        sys_rst <= 1'b0;
        repeat (2) @(negedge sys_clk);
        chk("cfg", 16'({7'h01, cna_pkg::RATE_125K}), 16'(activeCfg));
        chk("busOnline", 16'h1, 16'(busOnline));
        tick_gap(125);
        // every strobe refused outside edit mode
        for (int k = 0; k < 3; k++) ed(k, 7'h05, 1'b1);
        mode(1'b1);
        chk("busOnline", 16'h0, 16'(busOnline));
        ed(0, 7'h00, 1'b1);
        ed(1, 7'h07, 1'b1);
        for (int r = 6; r >= 0; r--) ed(1, 7'(r), 1'b0);
        nd = 7'((($random(seed) & 'h7f) % 126) + 2);
        ed(0, nd, 1'b0);
        mode(1'b0);
        // address staged but never saved stays out of use
        chk("cfg", 16'({7'h01, 3'h0}), 16'(activeCfg));
        mode(1'b1);
        ed(0, nd, 1'b0);
        ed(2, 7'h00, 1'b0);
        mode(1'b0);
        chk("cfg", 16'({nd, 3'h0}), 16'(activeCfg));
        tick_gap(1000);
        rx(1'b0, {4'hc, nd}, 1'b1);
        rx(1'b0, 11'h000, 1'b1);
        rx(1'b1, {4'hc, nd}, 1'b0);
        rx(1'b0, {4'hc, 7'(nd - 7'h01)}, 1'b0);
        for (int i = 0; i < 8; i++) begin
            rid = 11'($random(seed));
            rx(1'b0, rid, rid == {4'hc, nd} || rid[10:7] == 4'h0);
        end
        // alone on the bus
        send(cna_pkg::KIND_PDO, 1'b0);
        chk("won", 16'h1, 16'(w));
        chk("txId", 16'({4'h3, nd}), 16'(txId));
        send(cna_pkg::KIND_SDO, 1'b0);
        chk("won", 16'h1, 16'(w));
        chk("txId", 16'({4'hb, nd}), 16'(txId));
        // contention: own process data beats a peer service frame, then loses to a lower address
        @(posedge sys_clk);
        peerId <= {4'hb, nd};
        contend <= 1'b1;
        send(cna_pkg::KIND_PDO, 1'b0);
        chk("won", 16'h1, 16'(w));
        @(posedge sys_clk);
        peerId <= {4'h3, 7'(nd - 7'h01)};
        send(cna_pkg::KIND_PDO, 1'b0);
        chk("won", 16'h0, 16'(w));
        // occupied bus holds the request back
        @(posedge sys_clk);
        contend <= 1'b0;
        hold <= 1'b1;
        txReq <= 1'b1;
        repeat (400) @(negedge sys_clk);
        chk("txBusy", 16'h0, 16'(txBusy));
        @(posedge sys_clk);
        hold <= 1'b0;
        send(cna_pkg::KIND_PDO, 1'b0);
        chk("won", 16'h1, 16'(w));
        // edit mode in mid-frame aborts and silences
        send(cna_pkg::KIND_PDO, 1'b1);
        chk("won", 16'h0, 16'(w));
        rx(1'b0, {4'hc, nd}, 1'b0);
        mode(1'b0);
        rx(1'b0, {4'hc, nd}, 1'b1);
        report_and_stop();
    end
endmodule
